// [rtl/asr_port.sv]
`timescale 1ns/1ps
module asr_port (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        port_format_select,
  input  wire logic        clock_source_select,
  input  wire logic        clk_invert,
  input  wire logic        convert_start_n,
  input  wire logic        chip_select_n,
  input  wire logic        read_enable_n,
  input  wire logic        read_timing_or_chain_input,
  input  wire logic [15:0] result_data,
  input  wire logic        result_valid,
  output logic             result_ready,
  input  wire logic        shift_clk_i,
  output logic             shift_clk_o,
  output logic             shift_clk_oe,
  output logic             serial_result_out,
  output logic             serial_result_oe,
  output logic             frame_sync,
  output logic             busy,
  output logic             late_read_error
);
  // Synchronised pins
  logic cnv_n_s;
  logic cs_n_s;
  logic rd_n_s;
  logic timing_s;
  logic sclk_s;
  logic [4:0] pin_raw;
  logic [4:0] pin_syn;
  // Active-low pins enter inverted so the cleared synchroniser matches their idle level;
  // otherwise reset release would show a false convert edge and a false select
  assign pin_raw = {~convert_start_n, ~chip_select_n, ~read_enable_n, read_timing_or_chain_input, shift_clk_i};
  assign {cnv_n_s, cs_n_s, rd_n_s, timing_s, sclk_s} = pin_syn ^ 5'h1C;

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      asr_sync u_sync (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .din     (pin_raw[gi]),
        .dout    (pin_syn[gi])
      );
    end
  endgenerate

  // Result fifo between converter core and serial port
  logic [15:0] fifo_data;
  logic        fifo_valid;
  logic        fifo_pop;
  asr_fifo #(
    .WIDTH (asr_pkg::RES_W),
    .DEPTH (asr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .in_data   (result_data),
    .in_valid  (result_valid),
    .in_ready  (result_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  asr_pkg::asr_mode_s mode;
  assign mode.serial_en  = port_format_select;
  assign mode.slave      = clock_source_select;
  assign mode.read_after = timing_s;
  assign mode.invert     = clk_invert;

  // Chained read-after slave uses the pin as data; chain mode comes from the slave select alone
  logic chain_mode;
  assign chain_mode = mode.slave;

  asr_pkg::asr_state_e st_q, st_d;
  logic [15:0] sh_q, sh_d;
  logic [4:0]  bit_q, bit_d;
  logic [3:0]  div_q, div_d;
  logic        mclk_q, mclk_d;
  logic        sync_q, sync_d;
  logic        conv_q, conv_d;
  logic [7:0]  ccnt_q, ccnt_d;
  logic        cnv_prev_q;
  logic        sclk_prev_q;
  logic        err_q, err_d;
  logic        hold_q, hold_d;
  logic        chain_q, chain_d;
  logic        sdo_q, sdo_d;
  logic        sel_n;
  logic        s_rise;
  logic        s_fall;
  logic        conv_done;
  logic        cnv_fall;

  assign sel_n     = cs_n_s | rd_n_s;
  // Host clock edges found by sampling; host rate must stay well below a quarter of ref_clk
  assign s_rise    = sclk_s && !sclk_prev_q;
  assign s_fall    = !sclk_s && sclk_prev_q;
  assign cnv_fall  = !cnv_n_s && cnv_prev_q;
  assign conv_done = conv_q && (ccnt_q == 8'h01);
  assign fifo_pop  = (st_q == asr_pkg::ASR_IDLE) && fifo_valid && !conv_q && !hold_q && mode.serial_en;

  // Conversion timer, shift engine and error pulse
  always_comb begin
    st_d    = st_q;
    sh_d    = sh_q;
    bit_d   = bit_q;
    div_d   = div_q;
    mclk_d  = mclk_q;
    sync_d  = sync_q;
    conv_d  = conv_q;
    ccnt_d  = ccnt_q;
    err_d   = 1'b0;
    hold_d  = hold_q;
    chain_d = chain_q;
    sdo_d   = sdo_q;
    // Conversion cannot be restarted while running
    if (cnv_fall && !conv_q) begin
      conv_d = 1'b1;
      ccnt_d = asr_pkg::CONV_CYC;
    end else if (conv_q) begin
      ccnt_d = 8'(ccnt_q - 8'h01);
      if (conv_done) begin
        conv_d = 1'b0;
      end
    end
    // Previous result not fully read when conversion ends
    if (conv_done && st_q == asr_pkg::ASR_SHIFT && mode.slave && !mode.read_after) begin
      err_d = 1'b1;
    end
    case (st_q)
      asr_pkg::ASR_IDLE: begin
        mclk_d = 1'b0;
        sync_d = 1'b0;
        if (fifo_pop && mode.serial_en) begin
          sh_d   = fifo_data;
          bit_d  = asr_pkg::BITS_PER_WORD;
          div_d  = asr_pkg::HALF_CYC;
          sdo_d  = fifo_data[15];
          hold_d = !mode.slave && mode.read_after;
          st_d   = asr_pkg::ASR_SHIFT;
        end
      end
      asr_pkg::ASR_SHIFT: begin
        if (!mode.slave) begin
          sync_d = 1'b1;
          if (div_q == 4'h1) begin
            div_d  = asr_pkg::HALF_CYC;
            mclk_d = !mclk_q;
            if (mclk_q) begin
              sh_d  = {sh_q[14:0], 1'b0};
              sdo_d = sh_q[14];
              bit_d = 5'(bit_q - 5'h01);
              if (bit_q == 5'h01) begin
                st_d   = asr_pkg::ASR_DONE;
                sync_d = 1'b0;
              end
            end
          end else begin
            div_d = 4'(div_q - 4'h1);
          end
        end else if (!sel_n) begin
          if (s_rise) begin
            chain_d = timing_s;
          end
          if (s_fall) begin
            sh_d  = {sh_q[14:0], chain_mode && mode.read_after ? chain_q : 1'b0};
            sdo_d = sh_q[14];
            // Chained reads clock past the word; count stops at zero so deselect ends the frame
            bit_d = (bit_q == 5'h00) ? 5'h00 : 5'(bit_q - 5'h01);
            if (bit_q == 5'h01 && !(chain_mode && mode.read_after)) begin
              st_d = asr_pkg::ASR_DONE;
            end
          end
        end
      end
      asr_pkg::ASR_DONE: begin
        mclk_d = 1'b0;
        sync_d = 1'b0;
        hold_d = 1'b0;
        st_d   = asr_pkg::ASR_IDLE;
      end
      default: begin
        st_d = asr_pkg::ASR_IDLE;
      end
    endcase
    // Chained slave ends its frame when the host deselects
    if (mode.slave && mode.read_after && sel_n && st_q == asr_pkg::ASR_SHIFT && bit_q == 5'h00) begin
      st_d = asr_pkg::ASR_DONE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_q        <= asr_pkg::ASR_IDLE;
      sh_q        <= 16'h0000;
      bit_q       <= 5'h00;
      div_q       <= 4'h0;
      mclk_q      <= 1'b0;
      sync_q      <= 1'b0;
      conv_q      <= 1'b0;
      ccnt_q      <= 8'h00;
      cnv_prev_q  <= 1'b1;
      sclk_prev_q <= 1'b0;
      err_q       <= 1'b0;
      hold_q      <= 1'b0;
      chain_q     <= 1'b0;
      sdo_q       <= 1'b0;
    end else begin
      st_q        <= st_d;
      sh_q        <= sh_d;
      bit_q       <= bit_d;
      div_q       <= div_d;
      mclk_q      <= mclk_d;
      sync_q      <= sync_d;
      conv_q      <= conv_d;
      ccnt_q      <= ccnt_d;
      cnv_prev_q  <= cnv_n_s;
      sclk_prev_q <= sclk_s;
      err_q       <= err_d;
      hold_q      <= hold_d;
      chain_q     <= chain_d;
      sdo_q       <= sdo_d;
    end
  end

  // Pads; serial data and shift clock float when deselected or in parallel format, other outputs are always driven
  always_comb begin
    shift_clk_o       = mclk_q ^ mode.invert;
    shift_clk_oe      = mode.serial_en && !mode.slave && !sel_n;
    serial_result_out = sdo_q;
    serial_result_oe  = mode.serial_en && !sel_n;
    frame_sync        = sync_q ^ mode.invert;
    busy              = conv_q || hold_q;
    late_read_error   = err_q;
  end

  // Strobe, once raised, covers at least the first two bit periods
  property p_sync_len;
    @(posedge ref_clk) disable iff (!resetn)
      $rose(sync_q) |-> sync_q [*8];
  endproperty
  a_sync_len: assert property (p_sync_len) else $error("frame strobe too short");

  // Strobe is gone once the frame has ended
  property p_sync_end;
    @(posedge ref_clk) disable iff (!resetn)
      (st_q == asr_pkg::ASR_DONE) |=> !sync_q;
  endproperty
  a_sync_end: assert property (p_sync_end) else $error("strobe after frame");

  // Either select line high floats both driven pins
  property p_float_sel;
    @(posedge ref_clk) disable iff (!resetn)
      sel_n |-> !serial_result_oe && !shift_clk_oe;
  endproperty
  a_float_sel: assert property (p_float_sel) else $error("drive while deselected");

  // Parallel format leaves the serial pins alone
  property p_float_par;
    @(posedge ref_clk) disable iff (!resetn)
      !port_format_select |-> !serial_result_oe && !shift_clk_oe;
  endproperty
  a_float_par: assert property (p_float_par) else $error("drive in parallel");

  // A disabled port must keep its results queued, not drop them
  property p_pop_gate;
    @(posedge ref_clk) disable iff (!resetn)
      !port_format_select |-> !fifo_pop;
  endproperty
  a_pop_gate: assert property (p_pop_gate) else $error("result lost while disabled");

  // Slave never fights the host on the clock pin
  property p_slave_clk;
    @(posedge ref_clk) disable iff (!resetn)
      clock_source_select |-> !shift_clk_oe;
  endproperty
  a_slave_clk: assert property (p_slave_clk) else $error("slave drives clock");

  // Late read error is a single-cycle pulse
  property p_err_pulse;
    @(posedge ref_clk) disable iff (!resetn)
      err_q |=> !err_q;
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("error not a pulse");

  // Held busy only falls after the frame has completed
  property p_busy_hold;
    @(posedge ref_clk) disable iff (!resetn)
      $fell(busy) && $past(hold_q) |-> $past(st_q) == asr_pkg::ASR_DONE;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

  // Between frames clock and strobe rest at the level chosen by the invert pin
  property p_idle_level;
    @(posedge ref_clk) disable iff (!resetn)
      (st_q == asr_pkg::ASR_IDLE) |-> frame_sync == clk_invert && shift_clk_o == clk_invert;
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle polarity");
endmodule

// [rtl/asr_pkg.sv]
package asr_pkg;

  // Result width and bit counter width
  localparam int unsigned RES_W = 16;
  localparam int unsigned CNT_W = 5;
  localparam logic [4:0]  BITS_PER_WORD = 5'h10;

  // Clock rate and master shift clock half period
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned MSCLK_HZ = 12500000;
  localparam int unsigned HALF_CYC_RAW = CLK_HZ / (2 * MSCLK_HZ);
  localparam logic [3:0]  HALF_CYC = (HALF_CYC_RAW < 1) ? 4'h1 : HALF_CYC_RAW[3:0];

  // Conversion time of the internal model in ns and cycles
  localparam int unsigned CONV_NS = 1000;
  localparam int unsigned CONV_CYC_RAW = (CONV_NS * (CLK_HZ / 1000000)) / 1000;
  localparam logic [7:0]  CONV_CYC = CONV_CYC_RAW[7:0];

  // Fifo depth of conversion results
  localparam int unsigned FIFO_DEPTH = 4;

  // Pin input synchroniser depth
  localparam int unsigned SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    ASR_IDLE  = 2'b00,
    ASR_SHIFT = 2'b01,
    ASR_DONE  = 2'b11
  } asr_state_e;

  // Mode straps sampled from pins
  typedef struct packed {
    logic serial_en;
    logic slave;
    logic read_after;
    logic invert;
  } asr_mode_s;

  // Pad pair for the serial output
  typedef struct packed {
    logic o;
    logic oe;
  } asr_pad_s;

endpackage

// [rtl/asr_sync.sv]
`timescale 1ns/1ps
// Three flop synchroniser; a change counts when the last two agree
module asr_sync (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic din,
  output logic      dout
);
  logic [2:0] sh_q;
  logic [2:0] sh_d;
  logic       out_q;
  logic       out_d;

  // Stage one feeds only stage two
  always_comb begin
    sh_d  = {sh_q[1:0], din};
    out_d = (sh_q[2] == sh_q[1]) ? sh_q[2] : out_q;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sh_q  <= 3'h0;
      out_q <= 1'b0;
    end else begin
      sh_q  <= sh_d;
      out_q <= out_d;
    end
  end

  assign dout = out_q;
endmodule

// [rtl/asr_fifo.sv]
`timescale 1ns/1ps
// Small result fifo with valid/ready on both sides
module asr_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    wp_d;
  logic [AW-1:0]    rp_q;
  logic [AW-1:0]    rp_d;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and count next state
  always_comb begin
    wp_d  = push ? AW'(wp_q + 1'b1) : wp_q;
    rp_d  = pop ? AW'(rp_q + 1'b1) : rp_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = (AW+1)'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = (AW+1)'(cnt_q - 1'b1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage has no reset; only written entries are read
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end
endmodule

// [sim/asr_host_model.sv]
`timescale 1ns/1ps
// Host side: starts conversions, selects the port, clocks reads
module asr_host_model (
  input  wire logic ref_clk,
  input  wire logic serial_result_out,
  output logic      convert_start_n,
  output logic      chip_select_n,
  output logic      read_enable_n,
  output logic      host_clk,
  output logic      chain_out
);
  // Idle host: deselected, clock parked low, read-after strap
  initial begin
    convert_start_n = 1'b1;
    chip_select_n   = 1'b1;
    read_enable_n   = 1'b1;
    host_clk        = 1'b0;
    chain_out       = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Low pulse long enough to clear the pin synchroniser
  task automatic convert();
    tick(1);
    convert_start_n = 1'b0;
    tick(4);
    convert_start_n = 1'b1;
  endtask

  task automatic select(input logic sel_n);
    tick(1);
    chip_select_n = sel_n;
    read_enable_n = sel_n;
  endtask

  // Fixed strap level; only changed between conversions
  task automatic set_pin(input logic v);
    chain_out = v;
  endtask

  // Gated 160 ns clock, 2 cycles active, 6 idle; bit taken before each active edge
  task automatic read(input int n, input logic idle, input logic sel_n, input logic chain,
                      output logic [31:0] word);
    int i;
    word = 32'h0;
    tick(1);
    host_clk = idle;
    chain_out = chain;
    chip_select_n = sel_n;
    read_enable_n = sel_n;
    tick(6);
    for (i = 0; i < n; i++) begin
      word = {word[30:0], serial_result_out};
      host_clk = ~idle;
      tick(2);
      host_clk = idle;
      tick(6);
    end
  endtask
endmodule

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
  localparam logic [15:0] WORDS [0:4] = '{16'hA5C3, 16'h8001, 16'h7FFE, 16'h0F0F, 16'h1234};
  logic        ref_clk;
  logic        resetn;
  logic        port_format_select;
  logic        clock_source_select;
  logic        clk_invert;
  logic [15:0] result_data;
  logic        result_valid;
  logic        result_ready, shift_clk_o, shift_clk_oe, serial_result_out, serial_result_oe;
  logic        frame_sync, busy, late_read_error, convert_start_n, chip_select_n, read_enable_n;
  logic        host_clk, read_timing_or_chain_input, sclk_wire;
  int          n_errors = 0;
  int          n_compared = 0;

  // Shared clock pin: the driving side wins, else the host
  assign sclk_wire = shift_clk_oe ? shift_clk_o : host_clk;

  always #10 ref_clk = ~ref_clk;

  asr_port u_dut (.ref_clk, .resetn, .port_format_select, .clock_source_select, .clk_invert,
    .convert_start_n, .chip_select_n, .read_enable_n, .read_timing_or_chain_input, .result_data,
    .result_valid, .result_ready, .shift_clk_i(sclk_wire), .shift_clk_o, .shift_clk_oe,
    .serial_result_out, .serial_result_oe, .frame_sync, .busy, .late_read_error);

  asr_host_model u_host (.ref_clk, .serial_result_out, .convert_start_n, .chip_select_n,
    .read_enable_n, .host_clk, .chain_out(read_timing_or_chain_input));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic logic probe(input int which);
    case (which)
      0: probe = busy;
      1: probe = frame_sync ^ clk_invert;
      default: probe = late_read_error;
    endcase
  endfunction

  // Bounded wait; a run-out ends the test
  task automatic wait_for(input int which, input logic val, input int bound);
    int i;
    for (i = 0; i < bound && probe(which) !== val; i++) begin
      @(posedge ref_clk);
      #1;
    end
    check(probe(which), val);
    if (probe(which) !== val) conclude();
  endtask

  // Ready is settled after the edge, so the next edge takes the word
  task automatic push(input logic [15:0] w, output logic ok);
    int i;
    result_data = w;
    result_valid = 1'b1;
    ok = 1'b0;
    for (i = 0; i < 4 && !ok; i++) begin
      ok = (result_ready === 1'b1);
      @(posedge ref_clk);
      #1;
    end
    result_valid = 1'b0;
    // One idle edge so back-to-back pushes never retoggle valid in one step
    @(posedge ref_clk);
    #1;
  endtask

  // Collect one master frame on active clock edges
  task automatic master_frame(input logic [15:0] exp, input logic exp_busy);
    logic [31:0] word;
    int          cnt;
    int          i;
    logic        prev;
    logic        now;
    word = 32'h0;
    cnt = 0;
    wait_for(1, 1'b1, 300);
    prev = shift_clk_o ^ clk_invert;
    for (i = 0; i < 300 && probe(1) === 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
      now = shift_clk_o ^ clk_invert;
      if (now && !prev) begin
        word = {word[30:0], serial_result_out};
        cnt++;
        check({busy, shift_clk_oe, serial_result_oe}, {29'h0, exp_busy, 2'h3});
      end
      prev = now;
    end
    check(word, {16'h0, exp});
    check(cnt, 32'h10);
  endtask

  // Port disabled: fifo fills to its depth and neither serial pin is driven
  task automatic fill_stalled();
    logic ok;
    int   i;
    u_host.select(1'b0);
    for (i = 0; i < 5; i++) begin
      push(WORDS[i], ok);
      check(ok, i < 4);
      check({shift_clk_oe, serial_result_oe}, 32'h0);
    end
  endtask

  // Enabling the port drains all four words; busy drops after the last
  task automatic drain_master();
    int i;
    port_format_select = 1'b1;
    for (i = 0; i < 4; i++) master_frame(WORDS[i], 1'b1);
    wait_for(0, 1'b0, 10);
  endtask

  // Inverted clock and strobe in read-during mode; deselect floats both pins
  task automatic master_inverted();
    logic ok;
    u_host.select(1'b1);
    clk_invert = 1'b1;
    u_host.set_pin(1'b0);
    u_host.tick(6);
    check({shift_clk_oe, serial_result_oe}, 32'h0);
    check({frame_sync, shift_clk_o}, 32'h3);
    u_host.select(1'b0);
    push(WORDS[4], ok);
    master_frame(WORDS[4], 1'b0);
    u_host.select(1'b1);
    clk_invert = 1'b0;
    u_host.set_pin(1'b1);
  endtask

  // Host reads after busy falls; 17th bit is the chain input
  task automatic slave_after();
    logic        ok;
    logic [31:0] w;
    clock_source_select = 1'b1;
    push(16'hC3A5, ok);
    u_host.convert();
    wait_for(0, 1'b1, 20);
    wait_for(0, 1'b0, 200);
    u_host.read(17, 1'b0, 1'b0, 1'b1, w);
    u_host.select(1'b1);
    check(w[16:1], 16'hC3A5);
    check(w[0], 1'b1);
  endtask

  // Pulses while deselected are ignored; clock parked high
  task automatic slave_gated_high();
    logic        ok;
    logic [31:0] w;
    push(16'h5A3C, ok);
    u_host.convert();
    wait_for(0, 1'b1, 20);
    wait_for(0, 1'b0, 200);
    u_host.read(4, 1'b1, 1'b1, 1'b1, w);
    check(serial_result_oe, 1'b0);
    u_host.read(16, 1'b1, 1'b0, 1'b1, w);
    u_host.select(1'b1);
    check(w[15:0], 16'h5A3C);
  endtask

  // Previous result starts during conversion; unfinished read flags an error
  task automatic slave_during_late();
    logic        ok;
    logic [31:0] w;
    u_host.read(0, 1'b0, 1'b1, 1'b0, w);
    u_host.set_pin(1'b0);
    push(16'h9C61, ok);
    u_host.convert();
    wait_for(0, 1'b1, 20);
    wait_for(0, 1'b0, 200);
    push(16'h0000, ok);
    u_host.convert();
    wait_for(0, 1'b1, 20);
    u_host.read(2, 1'b0, 1'b0, 1'b0, w);
    check(w[1:0], 2'h2);
    wait_for(2, 1'b1, 100);
    u_host.select(1'b1);
  endtask

  // Reset, then scenarios in order
  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    port_format_select = 1'b0;
    clock_source_select = 1'b0;
    clk_invert = 1'b0;
    result_data = 16'h0000;
    result_valid = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    u_host.tick(4);
    fill_stalled();
    drain_master();
    master_inverted();
    slave_after();
    slave_gated_high();
    slave_during_late();
    conclude();
  end
endmodule
